/* File: rtl/asb_serial_datapath.sv */
// Buffer and shift-register datapath of the asynchronous serial unit.
`timescale 1ns/100ps
// What this block does
// - Each completed received byte is copied from the receive shifter into the receive buffer, unless an overrun drops it.
// - Seven-bit LSB-first data lands in bits 0 to 6; bit 7 reads zero.
// - Seven-bit MSB-first data lands in bits 1 to 7; bit 0 reads zero.
// - On overrun the new frame is dropped and the receive buffer keeps its contents.
// - Receive buffer is eight bits, read only, reset to all ones.
// - An internal, unaddressed shifter deserialises the serial input pin.
// - Writing the transmit buffer starts transmission of that byte.
// - Transmit buffer is eight bits, readable and writable, reset to all ones.
// - Buffer moves to shifter after first write, or in the same cycle as a done pulse when it is full.
// - Loading and output bits change on base clock falling edges; shifter is unaddressed.
module asb_serial_datapath
	import asb_pkg::*;
(
	input wire logic SYS_CLK_IN,
	input wire logic NRST_IN,
	input wire logic SERIAL_IN_PIN_IN,
	input asb_mode_t MODE_IN,
	input wire logic TX_WR_IN,
	input wire logic [7:0] TX_WR_DATA_IN,
	input wire logic RX_RD_IN,
	input wire logic OVERRUN_CLR_IN,
	output logic SERIAL_OUT_PIN_OUT,
	output logic [7:0] RX_BYTE_BUFFER_OUT,
	output logic [7:0] TX_BYTE_BUFFER_OUT,
	output logic TX_BUFFER_FULL_FLAG_OUT,
	output logic OVERRUN_ERROR_FLAG_OUT,
	output logic TX_DONE_INTERRUPT_OUT,
	output logic RX_DONE_OUT
);
	typedef struct packed {
		logic [1:0] div;
		logic tick;
		logic [2:0] sync;
		logic rx_level;
		logic [7:0] rx_byte_buffer;
		logic rx_unread;
		logic overrun_error_flag;
		logic rx_done;
		logic [7:0] tx_byte_buffer;
		logic tx_buffer_full_flag;
		asb_state_t tx_st;
		logic [3:0] tcnt;
		logic [3:0] bcnt;
		logic [7:0] tx_shifter;
		logic serial_out;
		logic tx_done_interrupt;
	} asb_top_state_t;

	asb_top_state_t r;
	asb_top_state_t next_r;
	logic shift_done;
	logic [7:0] shift_data;
	logic tx_on;
	logic [3:0] tx_last;

	assign tx_on = MODE_IN.power && MODE_IN.tx_en;
	assign tx_last = MODE_IN.len7 ? DATA7_LAST : DATA8_LAST;

	// Picks the shifter bit sent in data slot b, honouring length and order.
	function automatic logic tx_bit(input logic [7:0] sh, input logic [3:0] b,
		input asb_mode_t m);
		logic [2:0] idx;
		idx = 3'h0;
		if (m.lsb_first) begin
			idx = b[2:0];
		end else if (m.len7) begin
			idx = MSB7_POS - b[2:0];
		end else begin
			idx = MSB8_POS - b[2:0];
		end
		return sh[idx];
	endfunction

	asb_rx_shifter u_rx_shifter (
		.clk(SYS_CLK_IN),
		.nrst(NRST_IN),
		.tick(r.tick),
		.rx_level(r.rx_level),
		.mode(MODE_IN),
		.done(shift_done),
		.data(shift_data)
	);

	always_comb begin
		next_r = r;
		next_r.rx_done = 1'b0;
		next_r.tx_done_interrupt = 1'b0;

		// Base clock: the tick marks its falling edge, so all transmit moves happen on it.
		next_r.div = (r.div == DIV_LAST) ? 2'h0 : r.div + 2'h1;
		next_r.tick = (r.div == DIV_LAST);

		// The pin only counts as changed when the second and third stages agree.
		next_r.sync = {r.sync[1:0], SERIAL_IN_PIN_IN};
		if (r.sync[1] == r.sync[2]) begin
			next_r.rx_level = r.sync[2];
		end

		if (RX_RD_IN) begin
			next_r.rx_unread = 1'b0;
		end
		if (OVERRUN_CLR_IN) begin
			next_r.overrun_error_flag = 1'b0;
		end
		if (shift_done) begin
			next_r.rx_done = 1'b1;
			if (r.rx_unread && !RX_RD_IN) begin
				next_r.overrun_error_flag = 1'b1;
			end else begin
				next_r.rx_byte_buffer = shift_data;
				next_r.rx_unread = 1'b1;
			end
		end

		if (!tx_on) begin
			next_r.tx_st = ST_IDLE;
			next_r.serial_out = 1'b1;
		end else if (r.tick) begin
			case (r.tx_st)
				ST_IDLE: begin
					if (r.tx_buffer_full_flag) begin
						next_r.tx_shifter = r.tx_byte_buffer;
						next_r.tx_buffer_full_flag = 1'b0;
						next_r.tx_st = ST_START;
						next_r.tcnt = 4'h0;
						next_r.serial_out = 1'b0;
					end
				end
				ST_START: begin
					if (r.tcnt == TICK_LAST) begin
						next_r.tcnt = 4'h0;
						next_r.bcnt = 4'h0;
						next_r.tx_st = ST_DATA;
						next_r.serial_out = tx_bit(r.tx_shifter, 4'h0, MODE_IN);
					end else begin
						next_r.tcnt = r.tcnt + 4'h1;
					end
				end
				ST_DATA: begin
					if (r.tcnt == TICK_LAST) begin
						next_r.tcnt = 4'h0;
						if (r.bcnt == tx_last) begin
							next_r.tx_st = ST_STOP;
							next_r.serial_out = 1'b1;
						end else begin
							next_r.bcnt = r.bcnt + 4'h1;
							next_r.serial_out = tx_bit(r.tx_shifter, r.bcnt + 4'h1, MODE_IN);
						end
					end else begin
						next_r.tcnt = r.tcnt + 4'h1;
					end
				end
				ST_STOP: begin
					if (r.tcnt == TICK_LAST) begin
						next_r.tcnt = 4'h0;
						next_r.tx_done_interrupt = 1'b1;
						// Reloading in the same cycle as the done pulse keeps frames gapless.
						if (r.tx_buffer_full_flag) begin
							next_r.tx_shifter = r.tx_byte_buffer;
							next_r.tx_buffer_full_flag = 1'b0;
							next_r.tx_st = ST_START;
							next_r.serial_out = 1'b0;
						end else begin
							next_r.tx_st = ST_IDLE;
						end
					end else begin
						next_r.tcnt = r.tcnt + 4'h1;
					end
				end
				default: begin
					next_r.tx_st = ST_IDLE;
					next_r.serial_out = 1'b1;
				end
			endcase
		end

		// A write beats a same-cycle move, so a new byte is never lost.
		if (TX_WR_IN) begin
			next_r.tx_byte_buffer = TX_WR_DATA_IN;
			next_r.tx_buffer_full_flag = 1'b1;
		end
	end

	always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			r <= '{div: 2'h0, tick: 1'b0, sync: 3'h7, rx_level: 1'b1,
				rx_byte_buffer: BUF_RESET, rx_unread: 1'b0, overrun_error_flag: 1'b0,
				rx_done: 1'b0, tx_byte_buffer: BUF_RESET, tx_buffer_full_flag: 1'b0,
				tx_st: ST_IDLE, tcnt: 4'h0, bcnt: 4'h0, tx_shifter: BUF_RESET,
				serial_out: 1'b1, tx_done_interrupt: 1'b0};
		end else begin
			r <= next_r;
		end
	end

	assign SERIAL_OUT_PIN_OUT = r.serial_out;
	assign RX_BYTE_BUFFER_OUT = r.rx_byte_buffer;
	assign TX_BYTE_BUFFER_OUT = r.tx_byte_buffer;
	assign TX_BUFFER_FULL_FLAG_OUT = r.tx_buffer_full_flag;
	assign OVERRUN_ERROR_FLAG_OUT = r.overrun_error_flag;
	assign TX_DONE_INTERRUPT_OUT = r.tx_done_interrupt;
	assign RX_DONE_OUT = r.rx_done;
endmodule

/* File: rtl/asb_pkg.sv */
// Shared constants and types of the serial buffer datapath.
package asb_pkg;
	localparam int BASE_DIV = 4;
	localparam int BIT_TICKS = 16;
	localparam logic [1:0] DIV_LAST = 2'(BASE_DIV - 1);
	localparam logic [3:0] TICK_LAST = 4'(BIT_TICKS - 1);
	localparam logic [3:0] TICK_HALF = 4'(BIT_TICKS / 2 - 1);
	localparam logic [7:0] BUF_RESET = 8'hff;
	localparam logic [3:0] DATA7_LAST = 4'h6;
	localparam logic [3:0] DATA8_LAST = 4'h7;
	localparam logic [2:0] MSB7_POS = 3'h6;
	localparam logic [2:0] MSB8_POS = 3'h7;

	typedef struct packed {
		logic power;
		logic tx_en;
		logic rx_en;
		logic len7;
		logic lsb_first;
	} asb_mode_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_START = 2'h1,
		ST_DATA = 2'h3,
		ST_STOP = 2'h2
	} asb_state_t;
endpackage

/* File: rtl/asb_rx_shifter.sv */
// Receive shift register: turns the serial input into a packed byte.
`timescale 1ns/100ps
module asb_rx_shifter
	import asb_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic tick,
	input wire logic rx_level,
	input asb_mode_t mode,
	output logic done,
	output logic [7:0] data
);
	typedef struct packed {
		asb_state_t st;
		logic [3:0] tcnt;
		logic [3:0] bcnt;
		logic [7:0] sh;
		logic done;
		logic [7:0] data;
	} asb_rx_state_t;

	asb_rx_state_t r;
	asb_rx_state_t next_r;
	logic [3:0] last_bit;

	assign done = r.done;
	assign data = r.data;
	assign last_bit = mode.len7 ? DATA7_LAST : DATA8_LAST;

	always_comb begin
		next_r = r;
		next_r.done = 1'b0;
		if (!(mode.power && mode.rx_en)) begin
			next_r.st = ST_IDLE;
		end else if (tick) begin
			case (r.st)
				ST_IDLE: begin
					if (!rx_level) begin
						next_r.st = ST_START;
						next_r.tcnt = 4'h0;
					end
				end
				ST_START: begin
					if (r.tcnt == TICK_HALF) begin
						next_r.tcnt = 4'h0;
						next_r.bcnt = 4'h0;
						next_r.st = rx_level ? ST_IDLE : ST_DATA;
					end else begin
						next_r.tcnt = r.tcnt + 4'h1;
					end
				end
				ST_DATA: begin
					if (r.tcnt == TICK_LAST) begin
						next_r.tcnt = 4'h0;
						// Bits enter the register from one end or the other by bit order.
						next_r.sh = mode.lsb_first ? {rx_level, r.sh[7:1]} : {r.sh[6:0], rx_level};
						next_r.bcnt = r.bcnt + 4'h1;
						if (r.bcnt == last_bit) begin
							next_r.st = ST_STOP;
						end
					end else begin
						next_r.tcnt = r.tcnt + 4'h1;
					end
				end
				ST_STOP: begin
					if (r.tcnt == TICK_LAST) begin
						next_r.st = ST_IDLE;
						next_r.done = 1'b1;
						if (!mode.len7) begin
							next_r.data = r.sh;
						end else if (mode.lsb_first) begin
							next_r.data = {1'b0, r.sh[7:1]};
						end else begin
							next_r.data = {r.sh[6:0], 1'b0};
						end
					end else begin
						next_r.tcnt = r.tcnt + 4'h1;
					end
				end
				default: begin
					next_r.st = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			r <= '{st: ST_IDLE, tcnt: 4'h0, bcnt: 4'h0, sh: 8'h00, done: 1'b0, data: 8'h00};
		end else begin
			r <= next_r;
		end
	end
endmodule

/* File: dv/asb_peer.sv */
// Serial peer: drives the receive pin and decodes the transmit pin.
`timescale 1ns/100ps
module asb_peer (
	input wire logic clk_in,
	input wire logic pin_in,
	output logic line_out
);
	initial line_out = 1'b1;
	// One frame: start, n data bits, stop; line rests high afterwards.
	task automatic send(input logic [7:0] d, input int n, input logic lsb);
		for (int k = 0; k < n + 2; k++) begin
			@(posedge clk_in);
			line_out <= (k == 0) ? 1'b0 : (k > n) ? 1'b1 : d[lsb ? k - 1 : n - k];
			repeat (63) @(posedge clk_in);
		end
	endtask
	// Samples mid-bit so that edge jitter of a few clocks cannot matter.
	task automatic recv(input int n, input logic lsb, output logic [7:0] r);
		int t;
		r = 8'h00;
		t = 0;
		while (pin_in !== 1'b0 && t < 3000) begin
			@(negedge clk_in);
			t++;
		end
		repeat (32) @(negedge clk_in);
		for (int k = 0; k < n; k++) begin
			repeat (64) @(negedge clk_in);
			if (lsb) r[k] = pin_in;
			else r = {r[6:0], pin_in};
		end
		repeat (64) @(negedge clk_in);
	endtask
endmodule

/* File: dv/asb_serial_datapath_properties.sv */
// Port assertions of the serial datapath.
`timescale 1ns/100ps
module asb_props
	import asb_pkg::*;
(
	input wire logic SYS_CLK_IN,
	input wire logic NRST_IN,
	input asb_mode_t MODE_IN,
	input wire logic TX_WR_IN,
	input wire logic [7:0] TX_WR_DATA_IN,
	input wire logic SERIAL_OUT_PIN_OUT,
	input wire logic [7:0] RX_BYTE_BUFFER_OUT,
	input wire logic [7:0] TX_BYTE_BUFFER_OUT,
	input wire logic TX_BUFFER_FULL_FLAG_OUT,
	input wire logic OVERRUN_ERROR_FLAG_OUT,
	input wire logic TX_DONE_INTERRUPT_OUT,
	input wire logic RX_DONE_OUT
);
	default clocking @(posedge SYS_CLK_IN); endclocking
	default disable iff (!NRST_IN);
	property p_wr;
		TX_WR_IN |=> TX_BYTE_BUFFER_OUT == $past(TX_WR_DATA_IN) && TX_BUFFER_FULL_FLAG_OUT;
	endproperty
	a_wr: assert property (p_wr) else $error("tx write lost");
	property p_ro;
		$changed(RX_BYTE_BUFFER_OUT) |-> RX_DONE_OUT;
	endproperty
	a_ro: assert property (p_ro) else $error("rx buffer changed alone");
	property p_ovr;
		$rose(OVERRUN_ERROR_FLAG_OUT) |-> $stable(RX_BYTE_BUFFER_OUT);
	endproperty
	a_ovr: assert property (p_ovr) else $error("overrun frame stored");
	property p_l7;
		$changed(RX_BYTE_BUFFER_OUT) && MODE_IN.len7
			|-> !(MODE_IN.lsb_first ? RX_BYTE_BUFFER_OUT[7] : RX_BYTE_BUFFER_OUT[0]);
	endproperty
	a_l7: assert property (p_l7) else $error("pad bit set");
	property p_load;
		$fell(TX_BUFFER_FULL_FLAG_OUT) && MODE_IN.tx_en |-> !SERIAL_OUT_PIN_OUT;
	endproperty
	a_load: assert property (p_load) else $error("no start bit on load");
	property p_bit;
		$changed(SERIAL_OUT_PIN_OUT) |=> $stable(SERIAL_OUT_PIN_OUT)[*8];
	endproperty
	a_bit: assert property (p_bit) else $error("tx bit too short");
	property p_rel;
		TX_DONE_INTERRUPT_OUT && $past(TX_BUFFER_FULL_FLAG_OUT) && !$past(TX_WR_IN)
			|-> !TX_BUFFER_FULL_FLAG_OUT && $past(SERIAL_OUT_PIN_OUT);
	endproperty
	a_rel: assert property (p_rel) else $error("no reload at done");
	property p_rxp;
		RX_DONE_OUT |=> !RX_DONE_OUT;
	endproperty
	a_rxp: assert property (p_rxp) else $error("rx done too long");
	c_tx: cover property (TX_DONE_INTERRUPT_OUT);
	c_rx: cover property (RX_DONE_OUT);
	c_ov: cover property ($rose(OVERRUN_ERROR_FLAG_OUT));
endmodule
bind asb_serial_datapath asb_props u_props (.*);

/* File: dv/tb.sv */
// Self-checking bench of the serial datapath.
`timescale 1ns/100ps
module tb;
	import asb_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic oclr = 1'b0;
	logic [7:0] wdata = 8'h00;
	asb_mode_t mode = '0;
	logic line, txd, full, ovr, txdone, rxdone;
	logic [7:0] rxb, txb;
	int n_errors = 0;
	int n_checks = 0;
	// Expected transmit frames, oldest first, as the peer should decode them.
	logic [7:0] tx_q[$];
	always #10 clk = ~clk;
	asb_serial_datapath dut (.SYS_CLK_IN(clk), .NRST_IN(nrst), .SERIAL_IN_PIN_IN(line),
		.MODE_IN(mode), .TX_WR_IN(wr), .TX_WR_DATA_IN(wdata), .RX_RD_IN(rd),
		.OVERRUN_CLR_IN(oclr), .SERIAL_OUT_PIN_OUT(txd), .RX_BYTE_BUFFER_OUT(rxb),
		.TX_BYTE_BUFFER_OUT(txb), .TX_BUFFER_FULL_FLAG_OUT(full),
		.OVERRUN_ERROR_FLAG_OUT(ovr), .TX_DONE_INTERRUPT_OUT(txdone), .RX_DONE_OUT(rxdone));
	asb_peer peer (.clk_in(clk), .pin_in(txd), .line_out(line));
	task check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task report_and_stop;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task wr_byte(input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task strobe(input int s);
		@(posedge clk);
		if (s == 1) oclr <= 1'b1;
		else rd <= 1'b1;
		@(posedge clk);
		oclr <= 1'b0;
		rd <= 1'b0;
	endtask
	task wait_rx;
		int t;
		t = 0;
		do begin
			@(negedge clk);
			t++;
		end while (rxdone !== 1'b1 && t < 1000);
		check("rx done", 8'(rxdone), 8'h01);
	endtask
	task run(input logic l7, input logic lsb, input logic rdb);
		logic [7:0] a, b, r, e;
		int n, t, u;
		n = l7 ? 7 : 8;
		a = 8'($urandom);
		b = a ^ 8'h5a;
		e = l7 ? (lsb ? {1'b0, a[6:0]} : {a[6:0], 1'b0}) : a;
		tx_q.push_back(l7 ? {1'b0, a[6:0]} : a);
		tx_q.push_back(l7 ? {1'b0, b[6:0]} : b);
		@(posedge clk);
		mode <= '{1'b1, 1'b1, 1'b1, l7, lsb};
		repeat (8) @(posedge clk);
		wr_byte(a);
		fork
			begin
				peer.recv(n, lsb, r);
				check("tx frame a", r, tx_q.pop_front());
				peer.recv(n, lsb, r);
				check("tx frame b", r, tx_q.pop_front());
				u = 0;
				do begin
					@(negedge clk);
					u++;
				end while (txdone !== 1'b1 && u < 100);
				check("tx done", 8'(txdone), 8'h01);
			end
			begin
				@(negedge clk);
				check("tx buffer", txb, a);
				t = 0;
				do begin
					@(negedge clk);
					t++;
				end while (full !== 1'b0 && t < 20);
				check("full clear", 8'(full), 8'h00);
				wr_byte(b);
			end
			begin
				// The done pulse falls inside the stop bit, before the peer lets go of it.
				fork
					peer.send(a, n, lsb);
					wait_rx;
				join
				check("rx buffer", rxb, e);
				if (rdb) strobe(0);
			end
		join
		if (!rdb) begin
			fork
				peer.send(b, n, lsb);
				wait_rx;
			join
			check("rx kept", rxb, e);
			check("overrun", 8'(ovr), 8'h01);
			strobe(1);
			@(negedge clk);
			check("overrun clr", 8'(ovr), 8'h00);
			strobe(0);
		end
	endtask
	initial begin
		void'($urandom(24));
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		@(negedge clk);
		check("rx reset", rxb, BUF_RESET);
		check("tx reset", txb, BUF_RESET);
		for (int m = 0; m < 4; m++) begin
			run(m[1], m[0], m != 3);
			$display("test %0d done", m);
		end
		report_and_stop;
	end
	// Four tests take about five and a half thousand cycles; this leaves ample margin.
	initial begin
		repeat (30000) @(posedge clk);
		n_errors++;
		report_and_stop;
	end
endmodule
